//--- hw/vrsc_top.v
// Purpose: Requester and system controller configuration registers with
//          the requester policy that steers bus request and release.
// Assumes: Arbiter grant and bus-busy handshake are simplified to a grant
//          level and a pending-request level; all pins but NRST active high here.
// Notes:   AXI4-Lite slave, one write and one read at a time.
`include "vrsc_map.vh"
module vrsc_top #(
  parameter SYSRESET_CYC = `VRSC_SYSRESET_NS / `VRSC_CLK_NS
) (
  input  wire        CLK_SYS,
  input  wire        NRST,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire        SYSCON_JUMPER,
  input  wire        INHIBIT_SYSFAIL,
  input  wire        WATCHDOG_TIMEOUT,
  input  wire        SYSRESET_IN,
  input  wire        BUS_GRANT,
  input  wire        BR_OTHERS,
  input  wire        CPU_CYCLE_DONE,
  input  wire        CPU_WANTS_BUS,
  output reg         SYSRESET_OUT,
  output reg         SYSFAIL_OUT,
  output reg         FAIL_LED,
  output reg         ROUND_ROBIN,
  output reg         BUS_REQUEST,
  output reg  [1:0]  BUS_REQUEST_LEVEL,
  output reg         BUS_BUSY
);
  localparam NEG_CYC =
    (`VRSC_NEG_MIN_NS + `VRSC_CLK_NS - 1) / `VRSC_CLK_NS;
  localparam REDRIVE_CYC =
    (`VRSC_REDRIVE_MIN_NS + `VRSC_CLK_NS - 1) / `VRSC_CLK_NS;
  // Requester states, one-hot
  localparam S_IDLE  = 4'h1;
  localparam S_REQ   = 4'h2;
  localparam S_OWN   = 4'h4;
  localparam S_WAIT  = 4'h8;

  // Synchronised pins
  wire [6:0] pin_s;
  wire       jumper_s  = pin_s[0];
  wire       inhib_s   = pin_s[1];
  wire       wdog_s    = pin_s[2];
  wire       sysrst_s  = pin_s[3];
  wire       grant_s   = pin_s[4];
  wire       br_oth_s  = pin_s[5];
  wire       done_s    = pin_s[6];

  vrsc_sync2 #(.W(7), .RST(0)) u_sync (
    .clk  (CLK_SYS),
    .nrst (NRST),
    .d    ({CPU_CYCLE_DONE, BR_OTHERS, BUS_GRANT, SYSRESET_IN,
            WATCHDOG_TIMEOUT, INHIBIT_SYSFAIL, SYSCON_JUMPER}),
    .q    (pin_s)
  );

  reg        want_s1_q;
  reg        want_q;
  reg        board_fail_q;
  reg        robin_q;
  reg        swrst_q;
  reg [31:0] swrst_cnt_q;
  reg [1:0]  level_wr_q;
  reg [1:0]  level_q;
  reg        never_rel_q;
  reg        rel_done_q;
  reg        req_neg_q;
  reg        hold_q;
  reg [3:0]  st_q;
  reg [2:0]  neg_cnt_q;
  reg        aw_hold_q;
  reg        w_hold_q;
  reg [7:0]  aw_addr_q;
  reg [31:0] w_data_q;
  reg        w_lane0_q;

  // Processor wish is an async pin too
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      want_s1_q <= 1'b0;
      want_q    <= 1'b0;
    end else begin
      want_s1_q <= CPU_WANTS_BUS;
      want_q    <= want_s1_q;
    end
  end

  // Register read value, shared by the read channel
  function [7:0] rd_val;
    input [7:0] a;
    begin
      if (a == `VRSC_ADDR_SYSCTL)
        rd_val = {4'h0, robin_q, board_fail_q, 1'b0, jumper_s};
      else if (a == `VRSC_ADDR_REQCFG)
        rd_val = {hold_q, st_q == S_OWN, req_neg_q, rel_done_q,
                  never_rel_q, 1'b0, level_q};
      else
        rd_val = 8'h00;
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `VRSC_ADDR_SYSCTL) || (a == `VRSC_ADDR_REQCFG);
    end
  endfunction

  // Either reset source clears the requester side
  wire any_rst = sysrst_s | swrst_q;

  // Write channel: address and data in either order, response after both
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0;
      w_lane0_q     <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `VRSC_RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= ~aw_hold_q & ~S_AXI_AWREADY & ~S_AXI_BVALID;
      S_AXI_WREADY  <= ~w_hold_q & ~S_AXI_WREADY & ~S_AXI_BVALID;
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_hold_q  <= 1'b1;
        w_data_q  <= S_AXI_WDATA;
        w_lane0_q <= S_AXI_WSTRB[0];
      end
      if (aw_hold_q & w_hold_q & ~S_AXI_BVALID) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= is_mapped(aw_addr_q) ? `VRSC_RESP_OKAY
                                             : `VRSC_RESP_SLVERR;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        S_AXI_AWREADY <= 1'b0;
        S_AXI_WREADY  <= 1'b0;
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Read channel: data one cycle after the address is taken
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= `VRSC_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & ~S_AXI_ARVALID
                       ? 1'b1 : (~S_AXI_RVALID & ~S_AXI_ARREADY);
      if (S_AXI_ARVALID & S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= {24'h0, rd_val(S_AXI_ARADDR)};
        S_AXI_RRESP   <= is_mapped(S_AXI_ARADDR) ? `VRSC_RESP_OKAY
                                                 : `VRSC_RESP_SLVERR;
      end else if (S_AXI_RVALID & S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Register write strobes, taken once both halves are held
  wire wr_sys_t = aw_hold_q & w_hold_q & ~S_AXI_BVALID & w_lane0_q &
                  (aw_addr_q == `VRSC_ADDR_SYSCTL);
  wire wr_req_t = aw_hold_q & w_hold_q & ~S_AXI_BVALID & w_lane0_q &
                  (aw_addr_q == `VRSC_ADDR_REQCFG);

  // System controller register and software reset pulse
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      board_fail_q <= 1'b1;
      robin_q      <= 1'b0;
      swrst_q      <= 1'b0;
      swrst_cnt_q  <= 32'h0;
    end else if (swrst_q) begin
      // Counting out the backplane reset; ends with the bit clear
      if (swrst_cnt_q == SYSRESET_CYC - 1) begin
        swrst_q     <= 1'b0;
        swrst_cnt_q <= 32'h0;
      end else begin
        swrst_cnt_q <= swrst_cnt_q + 32'h1;
      end
      board_fail_q <= 1'b1;
      robin_q      <= 1'b0;
    end else if (sysrst_s) begin
      board_fail_q <= 1'b1;
      robin_q      <= 1'b0;
    end else if (wr_sys_t) begin
      swrst_q      <= w_data_q[`VRSC_SC_SW_RESET];
      board_fail_q <= w_data_q[`VRSC_SC_BOARD_FAIL];
      robin_q      <= w_data_q[`VRSC_SC_ROBIN];
    end
  end

  // Release decision while owning the bus
  wire keep    = hold_q | never_rel_q;
  wire rel_now = ~keep & (rel_done_q ? (done_s & ~want_q)
                                     : br_oth_s);

  // Requester config; level lags until mastership is released
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      level_wr_q  <= `VRSC_LEVEL_RST;
      level_q     <= `VRSC_LEVEL_RST;
      never_rel_q <= 1'b0;
      rel_done_q  <= 1'b0;
      req_neg_q   <= 1'b0;
      hold_q      <= 1'b0;
    end else if (any_rst) begin
      level_wr_q  <= `VRSC_LEVEL_RST;
      level_q     <= `VRSC_LEVEL_RST;
      never_rel_q <= 1'b0;
      rel_done_q  <= 1'b0;
      req_neg_q   <= 1'b0;
      hold_q      <= 1'b0;
    end else begin
      if (wr_req_t) begin
        level_wr_q  <= w_data_q[`VRSC_RQ_LEVEL_HI:`VRSC_RQ_LEVEL_LO];
        never_rel_q <= w_data_q[`VRSC_RQ_NEVER_REL];
        rel_done_q  <= w_data_q[`VRSC_RQ_REL_DONE];
        req_neg_q   <= w_data_q[`VRSC_RQ_REQ_ON_NEG];
        hold_q      <= w_data_q[`VRSC_RQ_HOLD_BUS];
      end
      if (st_q == S_OWN && rel_now)
        level_q <= level_wr_q;
    end
  end

  // Requester state machine
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      st_q      <= S_IDLE;
      neg_cnt_q <= 3'h0;
    end else if (any_rst) begin
      st_q      <= S_IDLE;
      neg_cnt_q <= 3'h0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (hold_q | want_q) // never-release alone no request
            st_q <= S_REQ;
        end
        S_REQ: begin
          if (grant_s)
            st_q <= S_OWN;
        end
        S_OWN: begin
          if (rel_now) begin
            st_q      <= req_neg_q ? S_WAIT : S_IDLE;
            neg_cnt_q <= 3'h0;
          end
        end
        S_WAIT: begin
          // Negation seen for NEG_CYC, then quiet for REDRIVE_CYC
          if (br_oth_s && neg_cnt_q < NEG_CYC)
            neg_cnt_q <= 3'h0;
          else if (neg_cnt_q == NEG_CYC + REDRIVE_CYC)
            st_q <= S_IDLE;
          else
            neg_cnt_q <= neg_cnt_q + 3'h1;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Registered pin drives
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      SYSRESET_OUT      <= 1'b0;
      SYSFAIL_OUT       <= 1'b0;
      FAIL_LED          <= 1'b0;
      ROUND_ROBIN       <= 1'b0;
      BUS_REQUEST       <= 1'b0;
      BUS_REQUEST_LEVEL <= `VRSC_LEVEL_RST;
      BUS_BUSY          <= 1'b0;
    end else begin
      SYSRESET_OUT      <= swrst_q;
      SYSFAIL_OUT       <= board_fail_q & ~inhib_s;
      FAIL_LED          <= board_fail_q | wdog_s;
      ROUND_ROBIN       <= robin_q;
      BUS_REQUEST       <= (st_q == S_REQ);
      BUS_REQUEST_LEVEL <= level_q;
      BUS_BUSY          <= (st_q == S_OWN);
    end
  end

endmodule // vrsc_top

//--- hw/vrsc_map.vh
// Purpose: Register map and timing constants of the requester/system
//          controller configuration block.
// Assumes: AXI4-Lite word addressing, 10 MHz system clock.
// Notes:   Printed offsets are odd, so each one is kept as an index and
//          the byte address is four times the index.
`ifndef VRSC_MAP_VH
`define VRSC_MAP_VH

// Register indices and derived byte addresses
`define VRSC_IDX_SYSCTL       32'hfffe2001
`define VRSC_IDX_REQCFG       32'hfffe2003
`define VRSC_ADDR_SYSCTL      8'h04
`define VRSC_ADDR_REQCFG      8'h0c
`define VRSC_ADDR_W           8

// System controller config fields
`define VRSC_SC_IS_SYSCON     0
`define VRSC_SC_SW_RESET      1
`define VRSC_SC_BOARD_FAIL    2
`define VRSC_SC_ROBIN         3

// Requester config fields
`define VRSC_RQ_LEVEL_LO      0
`define VRSC_RQ_LEVEL_HI      1
`define VRSC_RQ_NEVER_REL     3
`define VRSC_RQ_REL_DONE      4
`define VRSC_RQ_REQ_ON_NEG    5
`define VRSC_RQ_HAS_BUS       6
`define VRSC_RQ_HOLD_BUS      7

// Reset values
`define VRSC_LEVEL_RST        2'h3

// Timing
`define VRSC_CLK_NS           100
`define VRSC_NEG_MIN_NS       150
`define VRSC_REDRIVE_MIN_NS   200
`define VRSC_SYSRESET_NS      200000

// AXI responses
`define VRSC_RESP_OKAY        2'h0
`define VRSC_RESP_SLVERR      2'h2

`endif

//--- hw/vrsc_sync2.v
// Purpose: Two-stage synchroniser for a vector of asynchronous levels.
// Assumes: Inputs are slow levels; no multi-bit coherence needed.
// Notes:   First stage feeds only the second stage.
module vrsc_sync2 #(
  parameter W   = 1,
  parameter RST = 0
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;

  // Two flops per bit against metastability
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= RST[W-1:0];
      q      <= RST[W-1:0];
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // vrsc_sync2

//--- test/vrsc_props.sv
// Purpose: Port assertions for the requester configuration block.
// Assumes: Pin inputs pass two sync flops and one output flop.
// Notes:   Pin checks wait five cycles to cover that latency.
module vrsc_props #(
  parameter int SYSRESET_CYC = 4
) (
  input wire logic       CLK_SYS,
  input wire logic       NRST,
  input wire logic       S_AXI_BVALID,
  input wire logic       S_AXI_BREADY,
  input wire logic       S_AXI_RVALID,
  input wire logic       S_AXI_RREADY,
  input wire logic       INHIBIT_SYSFAIL,
  input wire logic       WATCHDOG_TIMEOUT,
  input wire logic       SYSRESET_IN,
  input wire logic       SYSRESET_OUT,
  input wire logic       SYSFAIL_OUT,
  input wire logic       FAIL_LED,
  input wire logic       ROUND_ROBIN,
  input wire logic       BUS_REQUEST,
  input wire logic [1:0] BUS_REQUEST_LEVEL,
  input wire logic       BUS_BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  // Reset pulse must end well inside this bound
  localparam int SRST_MAX = SYSRESET_CYC + 8;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  property p_inh;
    INHIBIT_SYSFAIL [*5] |-> !SYSFAIL_OUT;
  endproperty
  a_inh: assert property (p_inh)
    else $error("fail line driven while inhibited");
  property p_wdog;
    WATCHDOG_TIMEOUT [*5] |-> FAIL_LED;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog did not light indicator");
  property p_robin;
    SYSRESET_IN [*5] |-> !ROUND_ROBIN;
  endproperty
  a_robin: assert property (p_robin)
    else $error("round robin kept through system reset");
  property p_srst;
    $rose(SYSRESET_OUT) |-> ##[1:SRST_MAX] !SYSRESET_OUT;
  endproperty
  a_srst: assert property (p_srst)
    else $error("software reset never cleared");
  property p_lvl;
    $changed(BUS_REQUEST_LEVEL) |-> !BUS_BUSY;
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("level changed while master");
  property p_own;
    $rose(BUS_BUSY) |-> $past(BUS_REQUEST);
  endproperty
  a_own: assert property (p_own)
    else $error("mastership without request");
  property p_bv;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
  endproperty
  a_bv: assert property (p_bv)
    else $error("write response dropped early");
  property p_rv;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID;
  endproperty
  a_rv: assert property (p_rv)
    else $error("read response dropped early");
endmodule // vrsc_props

//--- test/vrsc_arb_model.sv
// Purpose: Behavioural arbiter and other masters on the far side.
// Assumes: Grant is a level raised after the request stood a while.
// Notes:   Slow mode stretches the grant delay to exercise waits.
module vrsc_arb_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic req,
  input  wire logic busy,
  input  wire logic other_req,
  input  wire logic slow,
  output logic      grant,
  output logic      br_others
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  // Grant once the request has stood; withdrawn when the bus is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      grant <= 1'b0;
    end else begin
      cnt_q <= (req && !busy) ? cnt_q + {3'h0, cnt_q != 4'hf} : 4'h0;
      grant <= req && !busy && (cnt_q >= (slow ? 4'h9 : 4'h1));
    end
  end
  // Other master holds the shared request only while it wants the bus
  assign br_others = other_req;
endmodule // vrsc_arb_model

//--- test/vrsc_top_tb.sv
// Purpose: Self-checking bench for the requester configuration block.
// Assumes: Backplane reset loops back from the block's own reset output.
// Notes:   Short reset pulse parameter keeps the run brief.
`include "vrsc_map.vh"
bind vrsc_top vrsc_props #(.SYSRESET_CYC(4)) u_props (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .INHIBIT_SYSFAIL(INHIBIT_SYSFAIL),
  .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .SYSRESET_IN(SYSRESET_IN),
  .SYSRESET_OUT(SYSRESET_OUT), .SYSFAIL_OUT(SYSFAIL_OUT),
  .FAIL_LED(FAIL_LED), .ROUND_ROBIN(ROUND_ROBIN),
  .BUS_REQUEST(BUS_REQUEST), .BUS_REQUEST_LEVEL(BUS_REQUEST_LEVEL),
  .BUS_BUSY(BUS_BUSY));
module vrsc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] SC = `VRSC_ADDR_SYSCTL;
  localparam logic [7:0] RQ = `VRSC_ADDR_REQCFG;
  localparam logic [1:0] OK = `VRSC_RESP_OKAY;
  logic clk, nrst, awv, wv, bready, arv, rready, awrdy, wrdy, bvalid;
  logic arrdy, rvalid, jumper, inh, wdog, ext_rst, done, wants, oreq;
  logic slow, sro, sfo, led, robin, breq, busy, grant, br_oth, srin;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, lvl;
  logic [3:0] wstrb;
  int n_errors, samples_checked;
  // Backplane reset line is shared by this board and the outside
  assign srin = sro | ext_rst;
  always #50 clk = ~clk;
  vrsc_top #(.SYSRESET_CYC(4)) dut_u (.CLK_SYS(clk), .NRST(nrst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SYSCON_JUMPER(jumper),
    .INHIBIT_SYSFAIL(inh), .WATCHDOG_TIMEOUT(wdog), .SYSRESET_IN(srin),
    .BUS_GRANT(grant), .BR_OTHERS(br_oth), .CPU_CYCLE_DONE(done),
    .CPU_WANTS_BUS(wants), .SYSRESET_OUT(sro), .SYSFAIL_OUT(sfo),
    .FAIL_LED(led), .ROUND_ROBIN(robin), .BUS_REQUEST(breq),
    .BUS_REQUEST_LEVEL(lvl), .BUS_BUSY(busy));
  vrsc_arb_model arb_u (.clk(clk), .nrst(nrst), .req(breq), .busy(busy),
    .other_req(oreq), .slow(slow), .grant(grant), .br_others(br_oth));

  task end_of_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wt(input int k);
    repeat (k) @(posedge clk);
  endtask
  task stop_on(input int n);
    if (n >= 99) begin
      chk(8'h00, 8'h01);
      end_of_test();
    end
  endtask
  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic aw, w;
    n = 0;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (aw && awrdy === 1'b1) begin
        aw = 0;
        awv <= 1'b0;
      end
      if (w && wrdy === 1'b1) begin
        w = 0;
        wv <= 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 99);
    stop_on(n);
    bready <= 1'b0;
    chk({6'h0, bresp}, {6'h0, (a == SC || a == RQ) ? OK : 2'h2});
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arrdy === 1'b1)
        arv <= 1'b0;
    end while (rvalid !== 1'b1 && n < 99);
    stop_on(n);
    rready <= 1'b0;
    chk(rdata[7:0], e);
    chk({6'h0, rresp}, {6'h0, (a == SC || a == RQ) ? OK : 2'h2});
    @(posedge clk);
  endtask
  // Bounded wait: 0 watches mastership, 1 request, 2 reset output
  task automatic wfor(input int s, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (((s == 0) ? busy : (s == 1) ? breq : sro) !== v && n < 99);
    stop_on(n);
  endtask

  task t_pins;
    rd(SC, 8'h05);
    rd(RQ, 8'h03);
    rd(8'h10, 8'h00);
    wr(8'h10, 8'h00);
    wstrb <= 4'h0;
    wr(SC, 8'h08);
    wstrb <= 4'hf;
    rd(SC, 8'h05);
    chk({4'h0, led, sfo, lvl}, 8'h0f);
    wr(SC, 8'h08);
    wdog <= 1'b1;
    wt(6);
    chk({5'h0, robin, led, sfo}, 8'h06);
    wdog <= 1'b0;
    inh <= 1'b1;
    jumper <= 1'b0;
    wr(SC, 8'h0c);
    wt(6);
    chk({6'h0, led, sfo}, 8'h02);
    rd(SC, 8'h0c);
    inh <= 1'b0;
    jumper <= 1'b1;
    wr(SC, 8'h0a);
    wfor(2, 1'b1);
    wfor(2, 1'b0);
    wt(6);
    rd(SC, 8'h05);
    wr(SC, 8'h08);
    ext_rst <= 1'b1;
    wt(8);
    ext_rst <= 1'b0;
    wt(6);
    rd(SC, 8'h05);
  endtask
  task t_hold;
    wr(RQ, 8'h83);
    wfor(0, 1'b1);
    rd(RQ, 8'hc3);
    oreq <= 1'b1;
    wt(8);
    chk({7'h0, busy}, 8'h01);
    wr(RQ, 8'h0b);
    wt(8);
    chk({6'h0, busy, breq}, 8'h02);
    wr(RQ, 8'h03);
    wfor(0, 1'b0);
    rd(RQ, 8'h03);
    oreq <= 1'b0;
    wr(RQ, 8'h01);
    rd(RQ, 8'h03);
    slow <= 1'b1;
    wants <= 1'b1;
    wfor(0, 1'b1);
    wt(8);
    chk({5'h0, busy, lvl}, 8'h07);
    oreq <= 1'b1;
    wfor(0, 1'b0);
    wt(4);
    chk({6'h0, lvl}, 8'h01);
    rd(RQ, 8'h01);
  endtask
  task t_release;
    oreq <= 1'b0;
    slow <= 1'b0;
    wr(RQ, 8'h11);
    wfor(0, 1'b1);
    wt(4);
    chk({7'h0, busy}, 8'h01);
    wants <= 1'b0;
    done <= 1'b1;
    wfor(0, 1'b0);
    done <= 1'b0;
    wr(RQ, 8'h21);
    wants <= 1'b1;
    wfor(0, 1'b1);
    oreq <= 1'b1;
    wfor(0, 1'b0);
    wt(10);
    chk({7'h0, breq}, 8'h00);
    oreq <= 1'b0;
    wt(4);
    chk({7'h0, breq}, 8'h00);
    wfor(1, 1'b1);
  endtask

  // Hold reset 16 cycles, then work through the scenarios
  initial begin
    {clk, nrst, awv, wv, bready, arv, rready, inh, wdog} = '0;
    {ext_rst, done, wants, oreq, slow} = '0;
    jumper = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    n_errors = 0;
    samples_checked = 0;
    wt(16);
    nrst <= 1'b1;
    wt(3);
    t_pins();
    t_hold();
    t_release();
    end_of_test();
  end
endmodule // vrsc_top_tb
